// file: shared/instr_timing_pkg.sv
package instr_timing_pkg;

  // cycle and byte counts used by the timing table
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_5 = 4'h5;
  localparam logic [3:0] CYC_8 = 4'h8;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // flag update mask field positions
  localparam int FLAG_CY_POS = 2;
  localparam int FLAG_AC_POS = 1;
  localparam int FLAG_OV_POS = 0;
  localparam logic [2:0] FLAGS_NONE  = 3'h0;
  localparam logic [2:0] FLAGS_ARITH = 3'h7;
  localparam logic [2:0] FLAGS_CARRY = 3'h4;
  localparam logic [2:0] FLAGS_MULDIV = 3'h5;

  // operand address: bit 7 splits low ram from the upper half
  localparam int ADDR_UPPER_POS = 7;

  // sequencer states
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_EXEC = 1'b1
  } seq_state_t;

  // operand addressing form
  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_REG  = 3'b001,
    MODE_DIR  = 3'b010,
    MODE_IND  = 3'b011,
    MODE_IMM  = 3'b100
  } op_mode_t;

  // complete state of the timing core
  typedef struct packed {
    seq_state_t  state;
    logic [3:0]  remain;
    logic [3:0]  base;
    logic [1:0]  len;
    logic        cond;
    logic        rel;
    logic        ext;
    logic        ext_wr;
    logic        code;
    op_mode_t    mode;
    logic [2:0]  flags;
    logic        extended;
    logic        started;
    logic [3:0]  elapsed;
    logic [15:0] pc;
    logic [15:0] target;
    logic        taken;
    logic        dir_sfr;
    logic        ind_upper;
    logic        ext_flash;
    logic        ext_onchip_expansion_ram;
  } core_state_t;

  localparam core_state_t STATE_RESET = '0;

endpackage

// file: src/opcode_timing_table.sv
`timescale 1ns/1ps
module opcode_timing_table (
  input  wire logic [7:0]                 opcode_in,
  output logic [1:0]                      len_out,
  output logic [3:0]                      cycles_out,
  output logic                            cond_out,
  output logic                            rel_out,
  output logic                            ext_out,
  output logic                            ext_wr_out,
  output logic                            code_out,
  output instr_timing_pkg::op_mode_t      mode_out,
  output logic [2:0]                      flags_out
);
  logic [3:0] hi;
  logic [3:0] lo;

  assign hi = opcode_in[7:4];
  assign lo = opcode_in[3:0];

  // bytes, untaken cycles and operand form per opcode column
  always_comb begin
    len_out    = instr_timing_pkg::LEN_1;
    cycles_out = instr_timing_pkg::CYC_1;
    cond_out   = 1'b0;
    rel_out    = 1'b0;
    ext_out    = 1'b0;
    ext_wr_out = 1'b0;
    code_out   = 1'b0;
    mode_out   = instr_timing_pkg::MODE_NONE;
    flags_out  = instr_timing_pkg::FLAGS_NONE;
    if (lo[3]) begin
      mode_out = instr_timing_pkg::MODE_REG;
      case (hi)
        4'h7, 4'h8, 4'hA: begin  // bank register with direct or immediate [RL18]
          len_out    = instr_timing_pkg::LEN_2;
          cycles_out = instr_timing_pkg::CYC_2;
        end
        4'hB: begin
          len_out    = instr_timing_pkg::LEN_3;
          cycles_out = instr_timing_pkg::CYC_3;
          cond_out   = 1'b1;
          rel_out    = 1'b1;
        end
        4'hD: begin
          len_out    = instr_timing_pkg::LEN_2;
          cycles_out = instr_timing_pkg::CYC_2;
          cond_out   = 1'b1;
          rel_out    = 1'b1;
        end
        default: ;  // one byte, one cycle [RL6] [RL17]
      endcase
    end else if (lo[3:1] == 3'h3) begin
      mode_out   = instr_timing_pkg::MODE_IND;
      cycles_out = instr_timing_pkg::CYC_2;  // indirect ram costs a cycle [RL8] [RL16]
      case (hi)
        4'h7, 4'h8, 4'hA: len_out = instr_timing_pkg::LEN_2;  // [RL15]
        4'hB: begin
          len_out    = instr_timing_pkg::LEN_3;
          cycles_out = instr_timing_pkg::CYC_4;
          cond_out   = 1'b1;
          rel_out    = 1'b1;
        end
        default: ;
      endcase
    end else if (lo == 4'h5) begin
      mode_out   = instr_timing_pkg::MODE_DIR;
      len_out    = instr_timing_pkg::LEN_2;
      cycles_out = instr_timing_pkg::CYC_2;  // [RL17]
      case (hi)
        4'h7, 4'h8: begin  // direct target with immediate or direct source [RL10]
          len_out    = instr_timing_pkg::LEN_3;
          cycles_out = instr_timing_pkg::CYC_3;
        end
        4'hA: begin  // spare opcode behaves as a no-op
          mode_out   = instr_timing_pkg::MODE_NONE;
          len_out    = instr_timing_pkg::LEN_1;
          cycles_out = instr_timing_pkg::CYC_1;
        end
        4'hB, 4'hD: begin
          len_out    = instr_timing_pkg::LEN_3;
          cycles_out = instr_timing_pkg::CYC_3;
          cond_out   = 1'b1;
          rel_out    = 1'b1;
        end
        default: ;
      endcase
    end else if (lo == 4'h4) begin
      case (hi)
        4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: ;  // accumulator only [RL9]
        4'h8: cycles_out = instr_timing_pkg::CYC_8;
        4'hA: cycles_out = instr_timing_pkg::CYC_4;
        4'hB: begin
          mode_out   = instr_timing_pkg::MODE_IMM;
          len_out    = instr_timing_pkg::LEN_3;
          cycles_out = instr_timing_pkg::CYC_3;
          cond_out   = 1'b1;
          rel_out    = 1'b1;
        end
        default: begin  // immediate operand [RL6]
          mode_out   = instr_timing_pkg::MODE_IMM;
          len_out    = instr_timing_pkg::LEN_2;
          cycles_out = instr_timing_pkg::CYC_2;
        end
      endcase
    end else if (lo == 4'h1) begin
      len_out    = instr_timing_pkg::LEN_2;
      cycles_out = instr_timing_pkg::CYC_3;
    end else begin
      case (opcode_in)
        8'h10, 8'h20, 8'h30: begin
          len_out    = instr_timing_pkg::LEN_3;
          cycles_out = instr_timing_pkg::CYC_3;
          cond_out   = 1'b1;
          rel_out    = 1'b1;
        end
        8'h40, 8'h50, 8'h60, 8'h70: begin
          len_out    = instr_timing_pkg::LEN_2;
          cycles_out = instr_timing_pkg::CYC_2;
          cond_out   = 1'b1;
          rel_out    = 1'b1;
        end
        8'h80: begin
          len_out    = instr_timing_pkg::LEN_2;
          cycles_out = instr_timing_pkg::CYC_3;
          rel_out    = 1'b1;
        end
        8'h02, 8'h12: begin
          len_out    = instr_timing_pkg::LEN_3;
          cycles_out = instr_timing_pkg::CYC_4;
        end
        8'h22, 8'h32: cycles_out = instr_timing_pkg::CYC_5;
        8'h90, 8'h43, 8'h53, 8'h63: begin  // pointer load, logic into direct [RL7] [RL11]
          len_out    = instr_timing_pkg::LEN_3;
          cycles_out = instr_timing_pkg::CYC_3;
        end
        8'h73: cycles_out = instr_timing_pkg::CYC_3;
        8'h83, 8'h93: begin  // code byte move [RL12]
          cycles_out = instr_timing_pkg::CYC_3;
          code_out   = 1'b1;
        end
        8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin  // external data move [RL13]
          cycles_out = instr_timing_pkg::CYC_3;
          ext_out    = 1'b1;
          ext_wr_out = hi[0];
        end
        8'h00, 8'h03, 8'h13, 8'h23, 8'h33, 8'hA3, 8'hB3, 8'hC3, 8'hD3: ;  // [RL9]
        default: begin  // direct byte or bit forms, push and pop [RL14]
          len_out    = instr_timing_pkg::LEN_2;
          cycles_out = instr_timing_pkg::CYC_2;
        end
      endcase
    end
    // flags touched, as in the classic set [RL1]
    if ((hi == 4'h2 || hi == 4'h3 || hi == 4'h9) && (lo >= 4'h4)) begin
      flags_out = instr_timing_pkg::FLAGS_ARITH;
    end else if (opcode_in == 8'h84 || opcode_in == 8'hA4) begin
      flags_out = instr_timing_pkg::FLAGS_MULDIV;
    end else if (hi == 4'hB && lo >= 4'h4) begin
      flags_out = instr_timing_pkg::FLAGS_CARRY;
    end else begin
      case (opcode_in)
        8'h13, 8'h33, 8'hD4, 8'hB3, 8'hC3, 8'hD3, 8'h72, 8'h82, 8'hA0, 8'hB0, 8'hA2:
          flags_out = instr_timing_pkg::FLAGS_CARRY;
        default: ;
      endcase
    end
  end

endmodule

// file: src/instr_timing_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// RL1: every opcode keeps the classic operation, addressing form and flag effects.
// RL2: timing is counted in plain system clocks, never in machine cycles.
// RL3: most instructions take as many clocks as they have bytes.
// RL4: a conditional branch not taken finishes one clock sooner than taken.
// RL5: external data move reaches only on-chip expansion ram or flash space.
// RL6: add, add with carry, subtract with borrow: reg 1/1, dir/imm 2/2, ind 1/2.
// RL7: logic op of immediate into direct byte is 3 bytes, 3 clocks.
// RL8: logic op into accumulator from indirect ram is 1 byte, 2 clocks.
// RL9: clear, complement, rotates and nibble swap of accumulator: 1 byte, 1 clock.
// RL10: direct to direct move is 3 bytes, 3 clocks.
// RL11: data pointer load with 16-bit constant is 3 bytes, 3 clocks.
// RL12: code byte move via data pointer or program counter: 1 byte, 3 clocks.
// RL13: all four external data moves are 1 byte, 3 clocks.
// RL14: push and pop of a direct byte are 2 bytes, 2 clocks each.
// RL15: accumulator to indirect 1/2; direct or immediate to indirect 2/2.
// RL16: low nibble exchange with indirect ram is 1 byte, 2 clocks.
// RL17: exchange with direct byte 2/2, with bank register 1/1.
// RL18: bank register to direct or direct to bank register: 2 bytes, 2 clocks.
// RL19: direct address 0x00-0x7f is data ram, 0x80-0xff is function registers.
// RL20: branch offset is signed 8 bits, relative to the following instruction.
// RL21: indirect above 0x7f reaches upper ram; direct there reaches registers.
// RL22: clock count runs from opcode fetch to the next opcode fetch.
module instr_timing_core (
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       fetch_valid_in,
  input  wire logic [7:0]                 opcode_in,
  input  wire logic [15:0]                opcode_addr_in,
  input  wire logic                       cond_true_in,
  input  wire logic [7:0]                 rel_in,
  input  wire logic [7:0]                 direct_addr_in,
  input  wire logic [7:0]                 indirect_addr_in,
  input  wire logic                       flash_select_in,
  output logic                            ready_out,
  output logic [1:0]                      len_out,
  output logic [3:0]                      cycles_out,
  output logic [3:0]                      elapsed_out,
  output instr_timing_pkg::op_mode_t      mode_out,
  output logic [2:0]                      flag_mask_out,
  output logic                            code_move_out,
  output logic                            branch_taken_out,
  output logic [15:0]                     branch_target_out,
  output logic                            direct_sfr_out,
  output logic                            direct_ram_out,
  output logic                            indirect_upper_out,
  output logic                            ext_flash_out,
  output logic                            ext_onchip_expansion_ram_out,
  output logic                            ext_write_out
);
  instr_timing_pkg::core_state_t st_reg;
  instr_timing_pkg::core_state_t st_next;

  logic [1:0]                 dec_len;
  logic [3:0]                 dec_cycles;
  logic                       dec_cond;
  logic                       dec_rel;
  logic                       dec_ext;
  logic                       dec_ext_wr;
  logic                       dec_code;
  instr_timing_pkg::op_mode_t dec_mode;
  logic [2:0]                 dec_flags;
  logic                       accept;
  logic                       decide;
  logic [15:0]                rel_target;

  // opcode lookup, one table shared by all columns
  opcode_timing_table u_table (
    .opcode_in  (opcode_in),
    .len_out    (dec_len),
    .cycles_out (dec_cycles),
    .cond_out   (dec_cond),
    .rel_out    (dec_rel),
    .ext_out    (dec_ext),
    .ext_wr_out (dec_ext_wr),
    .code_out   (dec_code),
    .mode_out   (dec_mode),
    .flags_out  (dec_flags)
  );

  // handshake: an opcode is taken only between instructions
  assign ready_out = (st_reg.state == instr_timing_pkg::SEQ_IDLE);
  assign accept    = fetch_valid_in && ready_out;

  // last untaken cycle of a relative branch decides the outcome
  assign decide = (st_reg.state == instr_timing_pkg::SEQ_EXEC) && st_reg.rel &&
                  (st_reg.remain == instr_timing_pkg::CYC_1) && !st_reg.extended;

  // target counts from the byte after the branch [RL20]
  assign rel_target = st_reg.pc + {14'h0000, st_reg.len} + {{8{rel_in[7]}}, rel_in};

  // next state of the sequencer and the address steering
  always_comb begin
    st_next       = st_reg;
    st_next.taken = 1'b0;
    // operand space: direct above 0x7f is a function register [RL19] [RL21]
    st_next.dir_sfr   = direct_addr_in[instr_timing_pkg::ADDR_UPPER_POS];
    // indirect above 0x7f stays in ram, upper half [RL21]
    st_next.ind_upper = indirect_addr_in[instr_timing_pkg::ADDR_UPPER_POS];
    // external move steers to flash or expansion ram, nothing off chip [RL5]
    st_next.ext_flash = 1'b0;
    st_next.ext_onchip_expansion_ram  = 1'b0;
    case (st_reg.state)
      instr_timing_pkg::SEQ_IDLE: begin
        if (accept) begin
          // latch decode; the fetch cycle is the first clock [RL2] [RL22]
          st_next.base     = dec_cycles;
          st_next.len      = dec_len;
          st_next.cond     = dec_cond;
          st_next.rel      = dec_rel;
          st_next.ext      = dec_ext;
          st_next.ext_wr   = dec_ext_wr;
          st_next.code     = dec_code;
          st_next.mode     = dec_mode;
          st_next.flags    = dec_flags;
          st_next.pc       = opcode_addr_in;
          st_next.extended = 1'b0;
          st_next.started  = 1'b1;
          st_next.elapsed  = instr_timing_pkg::CYC_1;
          st_next.remain   = dec_cycles - instr_timing_pkg::CYC_1;
          // bytes equal clocks for most opcodes through the pipeline [RL3]
          if (dec_cycles != instr_timing_pkg::CYC_1) begin
            st_next.state = instr_timing_pkg::SEQ_EXEC;
          end
          if (dec_ext && dec_cycles != instr_timing_pkg::CYC_1) begin
            st_next.ext_flash = flash_select_in;  // [RL5]
            st_next.ext_onchip_expansion_ram  = !flash_select_in;  // [RL5]
          end
        end
      end
      instr_timing_pkg::SEQ_EXEC: begin
        st_next.elapsed = st_reg.elapsed + instr_timing_pkg::CYC_1;
        if (st_reg.ext) begin
          st_next.ext_flash = flash_select_in;
          st_next.ext_onchip_expansion_ram  = !flash_select_in;
        end
        if (decide) begin
          st_next.target = rel_target;  // [RL20]
        end
        if (decide && st_reg.cond && cond_true_in) begin
          // taken branch holds one more clock [RL4]
          st_next.extended = 1'b1;
          st_next.taken    = 1'b1;
        end else begin
          st_next.taken  = decide && !st_reg.cond;
          st_next.remain = st_reg.remain - instr_timing_pkg::CYC_1;
          if (st_reg.remain == instr_timing_pkg::CYC_1) begin
            st_next.state     = instr_timing_pkg::SEQ_IDLE;  // [RL4] [RL22]
            st_next.ext_flash = 1'b0;
            st_next.ext_onchip_expansion_ram  = 1'b0;
          end
        end
      end
      default: st_next = instr_timing_pkg::STATE_RESET;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= instr_timing_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign len_out            = st_reg.len;
  assign cycles_out         = st_reg.base;
  assign elapsed_out        = st_reg.elapsed;
  assign mode_out           = st_reg.mode;
  assign flag_mask_out      = st_reg.flags;  // [RL1]
  assign code_move_out      = st_reg.code;
  assign branch_taken_out   = st_reg.taken;
  assign branch_target_out  = st_reg.target;
  assign direct_sfr_out     = st_reg.dir_sfr;
  assign direct_ram_out     = !st_reg.dir_sfr;
  assign indirect_upper_out = st_reg.ind_upper;
  assign ext_flash_out      = st_reg.ext_flash;
  assign ext_onchip_expansion_ram_out       = st_reg.ext_onchip_expansion_ram;
  assign ext_write_out      = st_reg.ext_wr;

  // checks on instruction timing and address steering
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  // busy for one or for two clocks, then free again; s_one_clk is free at once
  sequence s_two_clk;
    !ready_out ##1 ready_out;
  endsequence

  sequence s_three_clk;
    !ready_out [*2] ##1 ready_out;
  endsequence

  sequence s_one_clk;
    ready_out;
  endsequence

  a_fetch_to_fetch: assert property (  // [RL22] [RL2]
    ready_out && st_reg.started |->
      st_reg.elapsed == st_reg.base + {3'h0, st_reg.extended})
    else $error("clock count from fetch to fetch is wrong");

  a_bytes_match_clocks: assert property (  // [RL3]
    accept && (opcode_in[3] || opcode_in == 8'hE4) && opcode_in[7:4] != 4'h7 &&
    opcode_in[7:4] != 4'h8 && opcode_in[7:4] != 4'hA && opcode_in[7:4] != 4'hB &&
    opcode_in[7:4] != 4'hD |=> s_one_clk ##0 (len_out == 2'h1))
    else $error("register form not one byte one clock");

  a_arith_ind_two: assert property (  // [RL6]
    accept && opcode_in inside {8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97} |=>
      (len_out == 2'h1) ##0 s_two_clk)
    else $error("arithmetic indirect not 1 byte 2 clocks");

  a_arith_imm_dir: assert property (  // [RL6]
    accept && opcode_in inside {8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95} |=>
      (len_out == 2'h2) ##0 s_two_clk)
    else $error("arithmetic direct or immediate not 2 bytes 2 clocks");

  a_logic_imm_dir: assert property (  // [RL7]
    accept && opcode_in inside {8'h43, 8'h53, 8'h63} |=>
      (len_out == 2'h3) ##0 s_three_clk)
    else $error("logic immediate to direct not 3 bytes 3 clocks");

  a_logic_ind_acc: assert property (  // [RL8]
    accept && opcode_in inside {8'h46, 8'h47, 8'h56, 8'h57, 8'h66, 8'h67} |=>
      s_two_clk)
    else $error("logic from indirect not 2 clocks");

  a_acc_only_ops: assert property (  // [RL9]
    accept && opcode_in inside {8'hE4, 8'hF4, 8'h03, 8'h13, 8'h23, 8'h33, 8'hC4} |=>
      s_one_clk ##0 (mode_out == instr_timing_pkg::MODE_NONE))
    else $error("accumulator-only op not 1 clock");

  a_dir_dir_move: assert property (  // [RL10]
    accept && opcode_in == 8'h85 |=> (len_out == 2'h3) ##0 s_three_clk)
    else $error("direct to direct move not 3 clocks");

  a_pointer_load: assert property (  // [RL11]
    accept && opcode_in == 8'h90 |=> (len_out == 2'h3) ##0 s_three_clk)
    else $error("pointer load not 3 clocks");

  a_code_move_time: assert property (  // [RL12]
    accept && opcode_in inside {8'h83, 8'h93} |=>
      code_move_out && (len_out == 2'h1) ##0 s_three_clk)
    else $error("code byte move not 1 byte 3 clocks");

  a_ext_move_time: assert property (  // [RL13] [RL5]
    accept && opcode_in inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3} |=>
      (ext_flash_out != ext_onchip_expansion_ram_out) ##0 s_three_clk)
    else $error("external move not 3 clocks on chip");

  a_ext_target_sel: assert property (  // [RL5]
    ext_flash_out |-> !ext_onchip_expansion_ram_out && $past(flash_select_in))
    else $error("flash chosen without program store select");

  a_push_pop_time: assert property (  // [RL14]
    accept && opcode_in inside {8'hC0, 8'hD0} |=> (len_out == 2'h2) ##0 s_two_clk)
    else $error("push or pop not 2 bytes 2 clocks");

  a_ind_write_time: assert property (  // [RL15] [RL16]
    accept && opcode_in inside {8'hF6, 8'hF7, 8'hA6, 8'hA7, 8'h76, 8'h77,
                                8'hD6, 8'hD7} |=> s_two_clk)
    else $error("indirect write or nibble exchange not 2 clocks");

  a_exchange_time: assert property (  // [RL17]
    accept && opcode_in == 8'hC5 |=> (len_out == 2'h2) ##0 s_two_clk)
    else $error("direct exchange not 2 clocks");

  a_bank_direct: assert property (  // [RL18]
    accept && opcode_in[3] && (opcode_in[7:4] inside {4'h8, 4'hA}) |=>
      (mode_out == instr_timing_pkg::MODE_REG) ##0 s_two_clk)
    else $error("bank register and direct move not 2 clocks");

  a_branch_untaken: assert property (  // [RL4]
    decide && st_reg.cond && !cond_true_in |=> s_one_clk ##0 !branch_taken_out)
    else $error("untaken branch did not end a clock early");

  a_branch_taken: assert property (  // [RL4] [RL20]
    decide && st_reg.cond && cond_true_in |=>
      branch_taken_out && (branch_target_out == $past(rel_target)) ##0 s_two_clk)
    else $error("taken branch timing or target wrong");

  a_space_split: assert property (  // [RL19] [RL21]
    direct_sfr_out == $past(direct_addr_in[7]) && direct_ram_out != direct_sfr_out &&
      indirect_upper_out == $past(indirect_addr_in[7]))
    else $error("direct or indirect space selection wrong");

endmodule

// file: dv/pipelined_instruction_timing_tb.sv
`timescale 1ns/1ps
module pipelined_instruction_timing_tb;
  logic                       core_clk_in = 1'b0;
  logic                       rst_in = 1'b1;
  logic                       fetch_valid_in = 1'b0;
  logic                       cond_true_in = 1'b0;
  logic                       flash_select_in = 1'b0;
  logic [7:0]                 opcode_in = 8'h00;
  logic [7:0]                 rel_in = 8'h00;
  logic [7:0]                 direct_addr_in = 8'h00;
  logic [7:0]                 indirect_addr_in = 8'h00;
  logic [15:0]                opcode_addr_in = 16'h0000;
  logic                       ready_out, code_move_out, branch_taken_out, direct_sfr_out;
  logic                       direct_ram_out, indirect_upper_out, ext_flash_out;
  logic                       ext_onchip_expansion_ram_out, ext_write_out;
  logic [1:0]                 len_out;
  logic [3:0]                 cycles_out, elapsed_out;
  logic [2:0]                 flag_mask_out;
  logic [15:0]                branch_target_out;
  instr_timing_pkg::op_mode_t mode_out;
  int                         n_fail = 0, check_count = 0, cyc_count = 0, n;
  logic                       seen_taken, seen_flash, seen_onchip_expansion_ram;

  instr_timing_core instr_timing_core_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .fetch_valid_in(fetch_valid_in),
    .opcode_in(opcode_in), .opcode_addr_in(opcode_addr_in), .cond_true_in(cond_true_in),
    .rel_in(rel_in), .direct_addr_in(direct_addr_in), .indirect_addr_in(indirect_addr_in),
    .flash_select_in(flash_select_in), .ready_out(ready_out), .len_out(len_out),
    .cycles_out(cycles_out), .elapsed_out(elapsed_out), .mode_out(mode_out),
    .flag_mask_out(flag_mask_out), .code_move_out(code_move_out),
    .branch_taken_out(branch_taken_out), .branch_target_out(branch_target_out),
    .direct_sfr_out(direct_sfr_out), .direct_ram_out(direct_ram_out),
    .indirect_upper_out(indirect_upper_out), .ext_flash_out(ext_flash_out),
    .ext_onchip_expansion_ram_out(ext_onchip_expansion_ram_out), .ext_write_out(ext_write_out));

  // clock and hang guard
  always #10 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 5000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // offer one opcode, count clocks from its fetch until the next may be taken
  task automatic run_op(input logic [7:0] op, input logic [15:0] addr);
    @(posedge core_clk_in);
    fetch_valid_in <= 1'b1;
    opcode_in      <= op;
    opcode_addr_in <= addr;
    @(posedge core_clk_in);
    fetch_valid_in <= 1'b0;
    {seen_taken, seen_flash, seen_onchip_expansion_ram} = 3'b000;
    n = 0;
    do begin
      @(negedge core_clk_in);
      n++;
      seen_taken |= (branch_taken_out === 1'b1);
      seen_flash |= (ext_flash_out === 1'b1);
      seen_onchip_expansion_ram  |= (ext_onchip_expansion_ram_out === 1'b1);
    end while (ready_out !== 1'b1 && n < 12);
  endtask

  // entry: opcode, {length, clocks}, flag mask
  task automatic run_table(input logic [15:0] tbl[], input string name);
    foreach (tbl[k]) begin
      run_op(tbl[k][15:8], 16'h0040);
      check_val(16'(len_out), 16'(tbl[k][7:6]), "length");
      check_val(16'(cycles_out), 16'(tbl[k][5:4]), "clock count");
      check_val(16'(n), 16'(tbl[k][5:4]), "measured clocks");
      check_val(16'(elapsed_out), 16'(tbl[k][5:4]), "elapsed");
      check_val(16'(flag_mask_out), 16'(tbl[k][2:0]), "flags");
    end
    $display("test %s done", name);
  endtask

  task automatic test_branch(input logic [7:0] op, input logic c, input logic [7:0] rel,
                             input logic [15:0] addr, input int exp_n, input logic exp_t);
    cond_true_in <= c;
    rel_in       <= rel;
    run_op(op, addr);
    check_val(16'(n), 16'(exp_n), "branch clocks");
    check_val(16'(elapsed_out), 16'(exp_n), "branch elapsed");
    check_val(16'(seen_taken), 16'(exp_t), "taken pulse");
    if (exp_t)
      check_val(branch_target_out, addr + 16'h0002 + {{8{rel[7]}}, rel}, "target");
    $display("test branch %h done", op);
  endtask

  task automatic test_ext(input logic fl);
    logic [7:0] ops[4] = '{8'hE2, 8'hF2, 8'hE0, 8'hF0};
    flash_select_in <= fl;
    foreach (ops[k]) begin
      run_op(ops[k], 16'h0080);
      check_val(16'(n), 16'h0003, "ext clocks");
      check_val(16'(ext_write_out), 16'(ops[k][4]), "ext write");
      check_val(16'({seen_flash, seen_onchip_expansion_ram}), 16'({fl, ~fl}), "ext target");
    end
    $display("test external moves done");
  endtask

  task automatic test_steer(input logic [7:0] d, input logic [7:0] i);
    @(posedge core_clk_in);
    direct_addr_in   <= d;
    indirect_addr_in <= i;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    check_val(16'({direct_sfr_out, direct_ram_out}), 16'({d[7], ~d[7]}), "direct");
    check_val(16'(indirect_upper_out), 16'(i[7]), "indirect");
    $display("test steering %h %h done", d, i);
  endtask

  initial begin
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(negedge core_clk_in);
    check_val(16'({ready_out, len_out}), 16'h0004, "reset state");
    run_table('{16'h2857, 16'h25A7, 16'h2667, 16'h24A7, 16'h3857, 16'h35A7, 16'h3667,
                16'h34A7, 16'h9857, 16'h95A7, 16'h9667, 16'h94A7}, "arithmetic");
    run_table('{16'h53F0, 16'h43F0, 16'h63F0, 16'h5660, 16'h4660, 16'h6660}, "logic");
    run_table('{16'hE450, 16'hF450, 16'h2350, 16'h3354, 16'h0350, 16'h1354,
                16'hC450}, "accumulator");
    run_table('{16'h85F0, 16'h90F0, 16'h9370, 16'h8370, 16'hC0A0, 16'hD0A0}, "moves");
    run_table('{16'hF660, 16'hA6A0, 16'h76A0, 16'hD660, 16'hC5A0, 16'hC850,
                16'h88A0, 16'hA8A0}, "exchanges");
    test_branch(8'h60, 1'b0, 8'h10, 16'h0100, 2, 1'b0);
    test_branch(8'h60, 1'b1, 8'hFE, 16'h0100, 3, 1'b1);
    test_branch(8'h60, 1'b1, 8'h10, 16'h0200, 3, 1'b1);
    test_branch(8'h80, 1'b0, 8'h80, 16'h1000, 3, 1'b1);
    test_ext(1'b1);
    test_ext(1'b0);
    test_steer(8'h80, 8'h7F);
    test_steer(8'h7F, 8'h80);
    conclude();
  end
endmodule
